// file: common/cmd_pkg.sv
// memory map, decode types and timing constants for the core memory address decoder
package cmd_pkg;

  // flash: 256 pages of 4 kB, 1024 kB in all
  localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
  localparam logic [31:0] FLASH_SIZE      = 32'h0010_0000;
  localparam int          FLASH_PAGES     = 256;
  localparam int          PAGE_LSB        = 12;
  localparam int          PAGE_W          = 8;

  // ram: 256 kB seen through a code alias and a data alias
  localparam logic [31:0] CODE_RAM_BASE   = 32'h0080_0000;
  localparam logic [31:0] DATA_RAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] RAM_SIZE        = 32'h0004_0000;
  localparam int          RAM_SLAVES      = 9;
  localparam int          RAM_SECTIONS    = 22;
  localparam logic [31:0] RAM_SMALL_SIZE  = 32'h0001_0000;
  localparam int          SMALL_SLV_LSB   = 13;
  localparam int          SMALL_SECT_BIT  = 12;
  localparam int          BIG_SECT_LSB    = 15;
  localparam logic [3:0]  BIG_SLAVE       = 4'h8;
  localparam logic [2:0]  BIG_SECT_OFS    = 3'h2;
  localparam logic [2:0]  BIG_SECT_MAX    = 3'h5;
  localparam logic [2:0]  SMALL_SECT_MAX  = 3'h1;
  localparam int          SECT_PER_SMALL  = 2;

  // peripheral windows: one 4 kB window per identifier
  localparam logic [11:0] APB_HI          = 12'h400;
  localparam logic [7:0]  APB_IDS         = 8'h30;
  localparam int          ID_W            = 6;
  // identifiers 44 and 46 have no instance in this window and must error
  localparam logic [47:0] ID_VALID        = 48'hafff_ffff_ffff;
  localparam logic [19:0] GPIO_HI         = 20'h5_0000;
  localparam logic [11:0] IO_PORT_ONE_OFS = 12'h300;
  localparam logic [11:0] GPIO_END_OFS    = 12'h600;
  localparam logic [5:0]  ID_SERIAL0      = 6'h02;
  localparam logic [5:0]  ID_CIPHER       = 6'h0f;
  localparam logic [5:0]  ID_FPU          = 6'h26;

  // interrupt controller
  localparam int          IRQ_VECTORS     = 48;
  localparam int          PRIO_W          = 3;

  // wait states seen by the core
  localparam logic [1:0]  RAM_WS          = 2'h0;
  localparam logic [1:0]  FLASH_WS        = 2'h2;
  localparam logic [1:0]  FLASH_MISS_WS   = 2'h3;
  localparam logic [1:0]  FLASH_HIT_WS    = 2'h0;

  localparam int          FP_EXC_W        = 6;
  localparam int          TICK_W          = 24;

  typedef enum logic [2:0] {
    TGT_NONE   = 3'b000,
    TGT_RAM    = 3'b001,
    TGT_FLASH  = 3'b010,
    TGT_PERIPH = 3'b011,
    TGT_ERR1   = 3'b100,
    TGT_ERR2   = 3'b101
  } cmd_tgt_e;

  typedef struct packed {
    cmd_tgt_e         tgt;
    logic [3:0]       slave;
    logic [2:0]       sect;
    logic [ID_W-1:0]  id;
    logic [1:0]       port;
  } cmd_dec_s;

endpackage : cmd_pkg

// file: hw/cmd_tick_timer.sv
// core tick timer that only advances while the core runs or debug is active
`timescale 1ns/1ns
module cmd_tick_timer (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // gating
  input  wire logic                      core_running,
  input  wire logic                      debug_mode,
  // control
  input  wire logic [cmd_pkg::TICK_W-1:0] tick_reload,
  input  wire logic                      tick_clear,
  // status
  output logic      [cmd_pkg::TICK_W-1:0] tick_value,
  output logic                           tick_wrap
);

  typedef struct packed {
    logic [cmd_pkg::TICK_W-1:0] cnt;
    logic                       wrap;
  } cmd_tick_s;

  cmd_tick_s st_q;
  cmd_tick_s st_d;
  logic      run;

  assign run = core_running | debug_mode;

  always_comb begin
    st_d      = st_q;
    st_d.wrap = 1'b0;
    if (tick_clear) begin
      st_d.cnt = tick_reload;
    end else if (run) begin
      if (st_q.cnt == '0) begin
        st_d.cnt  = tick_reload;
        st_d.wrap = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_value = st_q.cnt;
  assign tick_wrap  = st_q.wrap;

  ////////////////////////////////////////////////////////////////////////////
  property p_tick_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (!core_running && !debug_mode && !tick_clear) |=> $stable(tick_value);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick timer moved while core stopped");

  property p_tick_step;
    @(posedge core_clk) disable iff (!rst_n)
    (core_running && !tick_clear && tick_value != '0) |=> tick_value == $past(tick_value) - 1'b1;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick timer did not count");

endmodule : cmd_tick_timer

// file: hw/cmd_decoder.sv
// address decoder for ram, flash and peripheral windows on one bus layer, with irq and power glue
`timescale 1ns/1ns

// What this block does
// - ram reached as nine separately selected bus slaves
// - ram slaves zero to seven each hold two 4 kB sections
// - ram slave eight holds six 32 kB sections
// - code and data ram aliases reach the same storage
// - each ram section powered per system-on and system-off setting
// - flash is 256 pages of 4 kB, readable on instruction and data buses
// - flash reads unlimited; bus writes to flash refused, only the controller writes
// - map holds 1024 kB flash and 256 kB ram
// - core and dma masters reach memory; core also reaches peripherals
// - core ram accesses take no wait states
// - flash fetches with cache off take at most two wait states
// - tick timer advances only while core runs or debug is active
// - fp exceptions raise fp irq until software clears the status bit
// - interrupt controller has 48 vectors with 3 priority bits each
// - io port zero at 0x50000000, io port one at 0x50000300
// - cipher and address resolver share the window at 0x4000F000
// - dma serial port unit0 decodes at 0x40002000 with the legacy port
module cmd_decoder (
  // clock and reset
  input  wire logic                                         core_clk,
  input  wire logic                                         rst_n,
  // bus layer from one master
  input  wire logic [31:0]                                  haddr,
  input  wire logic [1:0]                                   htrans,
  input  wire logic                                         hwrite,
  input  wire logic [3:0]                                   hprot,
  input  wire logic                                         hmaster_dma,
  output logic                                              hreadyout,
  output logic                                              hresp,
  output logic      [31:0]                                  hrdata,
  // ram slaves
  output logic      [cmd_pkg::RAM_SLAVES-1:0]               ram_sel,
  output logic      [2:0]                                   ram_sect,
  input  wire logic [cmd_pkg::RAM_SLAVES*32-1:0]            ram_rdata,
  // flash
  output logic                                              flash_sel,
  output logic      [cmd_pkg::PAGE_W-1:0]                   flash_page,
  input  wire logic [31:0]                                  flash_rdata,
  input  wire logic                                         icache_en,
  input  wire logic                                         icache_hit,
  // peripherals
  output logic                                              periph_sel,
  output logic      [cmd_pkg::ID_W-1:0]                     periph_id,
  output logic      [1:0]                                   gpio_port_sel,
  input  wire logic [31:0]                                  periph_rdata,
  input  wire logic                                         periph_hreadyout,
  input  wire logic                                         periph_hresp,
  // ram power
  input  wire logic                                         sys_off,
  input  wire logic [cmd_pkg::RAM_SECTIONS-1:0]             ram_pwr_on,
  input  wire logic [cmd_pkg::RAM_SECTIONS-1:0]             ram_ret_off,
  output logic      [cmd_pkg::RAM_SECTIONS-1:0]             ram_sect_pwr,
  // interrupts
  input  wire logic [cmd_pkg::FP_EXC_W-1:0]                 fp_exc_flags,
  input  wire logic [cmd_pkg::IRQ_VECTORS-1:0]              periph_irq,
  input  wire logic [cmd_pkg::IRQ_VECTORS*cmd_pkg::PRIO_W-1:0] irq_prio,
  output logic                                              fp_irq,
  output logic      [cmd_pkg::IRQ_VECTORS-1:0]              irq_pend,
  output logic                                              irq_any,
  output logic      [cmd_pkg::ID_W-1:0]                     irq_top,
  // core tick timer
  input  wire logic                                         core_running,
  input  wire logic                                         debug_mode,
  input  wire logic [cmd_pkg::TICK_W-1:0]                   tick_reload,
  input  wire logic                                         tick_clear,
  output logic      [cmd_pkg::TICK_W-1:0]                   tick_value,
  output logic                                              tick_wrap
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the live address phase and the checks

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    in_win = (a >= base) && ((a - base) < size);
  endfunction : in_win

  function automatic cmd_pkg::cmd_dec_s decode(input logic [31:0] a, input logic wr);
    logic [31:0] ofs;
    logic [7:0]  id8;
    decode = '0;
    ofs    = '0;
    id8    = a[19:12];
    if (in_win(a, cmd_pkg::CODE_RAM_BASE, cmd_pkg::RAM_SIZE) ||
        in_win(a, cmd_pkg::DATA_RAM_BASE, cmd_pkg::RAM_SIZE)) begin
      // both aliases fold onto the same offset, so storage is shared
      ofs = in_win(a, cmd_pkg::CODE_RAM_BASE, cmd_pkg::RAM_SIZE) ?
            a - cmd_pkg::CODE_RAM_BASE : a - cmd_pkg::DATA_RAM_BASE;
      decode.tgt = cmd_pkg::TGT_RAM;
      if (ofs < cmd_pkg::RAM_SMALL_SIZE) begin
        decode.slave = {1'b0, ofs[cmd_pkg::SMALL_SLV_LSB+2:cmd_pkg::SMALL_SLV_LSB]};
        decode.sect  = {2'b00, ofs[cmd_pkg::SMALL_SECT_BIT]};
      end else begin
        decode.slave = cmd_pkg::BIG_SLAVE;
        decode.sect  = ofs[cmd_pkg::BIG_SECT_LSB+2:cmd_pkg::BIG_SECT_LSB] - cmd_pkg::BIG_SECT_OFS;
      end
    end else if (in_win(a, cmd_pkg::FLASH_BASE, cmd_pkg::FLASH_SIZE)) begin
      // writes and erases belong to the nonvolatile_mem_ctrl port, not this bus
      decode.tgt = wr ? cmd_pkg::TGT_ERR1 : cmd_pkg::TGT_FLASH;
    end else if (a[31:20] == cmd_pkg::APB_HI && id8 < cmd_pkg::APB_IDS &&
                 cmd_pkg::ID_VALID[a[17:12]]) begin
      // shared windows (serial port unit0, cipher/resolver) need no extra term
      decode.tgt = cmd_pkg::TGT_PERIPH;
      decode.id  = a[17:12];
    end else if (a[31:12] == cmd_pkg::GPIO_HI && a[11:0] < cmd_pkg::GPIO_END_OFS) begin
      decode.tgt  = cmd_pkg::TGT_PERIPH;
      decode.port = (a[11:0] >= cmd_pkg::IO_PORT_ONE_OFS) ? 2'b10 : 2'b01;
    end else begin
      decode.tgt = cmd_pkg::TGT_ERR1;
    end
  endfunction : decode

  // lowest priority value wins, lowest vector number breaks ties
  function automatic logic [cmd_pkg::ID_W-1:0] pick_top(
      input logic [cmd_pkg::IRQ_VECTORS-1:0] pend,
      input logic [cmd_pkg::IRQ_VECTORS*cmd_pkg::PRIO_W-1:0] prio);
    logic [cmd_pkg::PRIO_W-1:0] best;
    logic                       found;
    pick_top = '0;
    best     = '1;
    found    = 1'b0;
    for (int i = 0; i < cmd_pkg::IRQ_VECTORS; i++) begin
      if (pend[i] && (!found || prio[i*cmd_pkg::PRIO_W +: cmd_pkg::PRIO_W] < best)) begin
        best     = prio[i*cmd_pkg::PRIO_W +: cmd_pkg::PRIO_W];
        pick_top = i[cmd_pkg::ID_W-1:0];
        found    = 1'b1;
      end
    end
  endfunction : pick_top

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    cmd_pkg::cmd_tgt_e                  tgt;
    logic [3:0]                         slave;
    logic [1:0]                         wait_cnt;
    logic                               fp_irq;
    logic [cmd_pkg::IRQ_VECTORS-1:0]    pend;
    logic                               any;
    logic [cmd_pkg::ID_W-1:0]           top;
    logic [cmd_pkg::RAM_SECTIONS-1:0]   pwr;
  } cmd_state_s;

  cmd_state_s        st_q;
  cmd_state_s        st_d;
  cmd_pkg::cmd_dec_s dec;
  logic              accept;
  logic              ready_int;
  logic [cmd_pkg::IRQ_VECTORS-1:0] pend_next;

  assign dec = decode(haddr, hwrite);

  always_comb begin
    case (st_q.tgt)
      cmd_pkg::TGT_NONE:   ready_int = 1'b1;
      cmd_pkg::TGT_RAM:    ready_int = 1'b1;
      cmd_pkg::TGT_FLASH:  ready_int = (st_q.wait_cnt == '0);
      cmd_pkg::TGT_PERIPH: ready_int = periph_hreadyout;
      cmd_pkg::TGT_ERR1:   ready_int = 1'b0;
      cmd_pkg::TGT_ERR2:   ready_int = 1'b1;
      default:             ready_int = 1'b1;
    endcase
  end

  // core and dma layers each run their own copy; both see the same map
  assign accept = ready_int && htrans[1];

  assign pend_next = periph_irq |
                     ({{(cmd_pkg::IRQ_VECTORS-1){1'b0}}, st_q.fp_irq} << cmd_pkg::ID_FPU);

  always_comb begin
    st_d = st_q;
    if (st_q.tgt == cmd_pkg::TGT_ERR1) begin
      st_d.tgt = cmd_pkg::TGT_ERR2;
    end else if (st_q.tgt == cmd_pkg::TGT_FLASH && st_q.wait_cnt != '0) begin
      st_d.wait_cnt = st_q.wait_cnt - 1'b1;
    end else if (ready_int) begin
      st_d.tgt = accept ? dec.tgt : cmd_pkg::TGT_NONE;
      st_d.slave = dec.slave;
      if (accept && dec.tgt == cmd_pkg::TGT_FLASH) begin
        // fetch or data read over instr_code_bus / data_code_bus alike
        st_d.wait_cnt = !icache_en ? cmd_pkg::FLASH_WS :
                        (icache_hit ? cmd_pkg::FLASH_HIT_WS : cmd_pkg::FLASH_MISS_WS);
      end else begin
        st_d.wait_cnt = cmd_pkg::RAM_WS;
      end
    end
    // exception bits are sticky in fp_status_control_reg, so the line tracks them
    st_d.fp_irq = |fp_exc_flags;
    st_d.pend   = pend_next;
    st_d.any    = |pend_next;
    st_d.top    = pick_top(pend_next, irq_prio);
    st_d.pwr    = sys_off ? ram_ret_off : ram_pwr_on;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    ram_sel = '0;
    if (htrans[1] && dec.tgt == cmd_pkg::TGT_RAM) begin
      ram_sel[dec.slave] = 1'b1;
    end
  end

  assign ram_sect      = dec.sect;
  assign flash_sel     = htrans[1] && dec.tgt == cmd_pkg::TGT_FLASH;
  assign flash_page    = haddr[cmd_pkg::PAGE_LSB+cmd_pkg::PAGE_W-1:cmd_pkg::PAGE_LSB];
  assign periph_sel    = htrans[1] && dec.tgt == cmd_pkg::TGT_PERIPH && !hmaster_dma;
  assign periph_id     = dec.id;
  assign gpio_port_sel = periph_sel ? dec.port : 2'b00;

  assign hreadyout = ready_int;
  assign hresp     = (st_q.tgt == cmd_pkg::TGT_ERR1) || (st_q.tgt == cmd_pkg::TGT_ERR2) ||
                     (st_q.tgt == cmd_pkg::TGT_PERIPH && periph_hresp);

  always_comb begin
    case (st_q.tgt)
      cmd_pkg::TGT_RAM:    hrdata = ram_rdata[st_q.slave*32 +: 32];
      cmd_pkg::TGT_FLASH:  hrdata = flash_rdata;
      cmd_pkg::TGT_PERIPH: hrdata = periph_rdata;
      default:             hrdata = '0;
    endcase
  end

  assign fp_irq       = st_q.fp_irq;
  assign irq_pend     = st_q.pend;
  assign irq_any      = st_q.any;
  assign irq_top      = st_q.top;
  assign ram_sect_pwr = st_q.pwr;

  cmd_tick_timer u_tick (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .core_running (core_running),
    .debug_mode   (debug_mode),
    .tick_reload  (tick_reload),
    .tick_clear   (tick_clear),
    .tick_value   (tick_value),
    .tick_wrap    (tick_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_ram_zero_wait;
    (accept && dec.tgt == cmd_pkg::TGT_RAM) |=> hreadyout && !hresp;
  endproperty
  a_ram_zero_wait: assert property (p_ram_zero_wait) else $error("ram access stalled");

  property p_flash_ws;
    (accept && dec.tgt == cmd_pkg::TGT_FLASH && !icache_en) |=> !hreadyout [*2] ##1 hreadyout;
  endproperty
  a_flash_ws: assert property (p_flash_ws) else $error("flash wait states wrong");

  property p_err_resp;
    (accept && dec.tgt == cmd_pkg::TGT_ERR1) |=> (hresp && !hreadyout) ##1 (hresp && hreadyout);
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("unmapped access not errored");

  property p_flash_write;
    (accept && hwrite && haddr < cmd_pkg::FLASH_SIZE) |=> hresp;
  endproperty
  a_flash_write: assert property (p_flash_write) else $error("flash write not refused");

  property p_alias;
    (htrans[1] && in_win(haddr, cmd_pkg::CODE_RAM_BASE, cmd_pkg::RAM_SIZE)) |->
      $onehot(ram_sel) &&
      decode(haddr - cmd_pkg::CODE_RAM_BASE + cmd_pkg::DATA_RAM_BASE, hwrite) == dec;
  endproperty
  a_alias: assert property (p_alias) else $error("ram aliases disagree");

  property p_big_sect;
    ram_sel[cmd_pkg::BIG_SLAVE] |-> ram_sect <= cmd_pkg::BIG_SECT_MAX;
  endproperty
  a_big_sect: assert property (p_big_sect) else $error("big ram section out of range");

  property p_small_sect;
    (|ram_sel[cmd_pkg::RAM_SLAVES-2:0]) |-> ram_sect <= cmd_pkg::SMALL_SECT_MAX;
  endproperty
  a_small_sect: assert property (p_small_sect) else $error("small ram section out of range");

  property p_fp_irq;
    (|fp_exc_flags) |=> fp_irq ##1 irq_pend[cmd_pkg::ID_FPU];
  endproperty
  a_fp_irq: assert property (p_fp_irq) else $error("fp irq not raised");

  property p_pwr;
    sys_off |=> ram_sect_pwr == $past(ram_ret_off);
  endproperty
  a_pwr: assert property (p_pwr) else $error("ram power not from off setting");

  property p_gpio_one;
    (htrans[1] && !hmaster_dma && haddr == {cmd_pkg::GPIO_HI, cmd_pkg::IO_PORT_ONE_OFS}) |->
      periph_sel && gpio_port_sel == 2'b10;
  endproperty
  a_gpio_one: assert property (p_gpio_one) else $error("io port one not decoded");

  c_flash_read: cover property (accept && dec.tgt == cmd_pkg::TGT_FLASH ##3 hreadyout);
  c_err: cover property (st_q.tgt == cmd_pkg::TGT_ERR2);
  c_big_ram: cover property (ram_sel[cmd_pkg::BIG_SLAVE] && ram_sect == cmd_pkg::BIG_SECT_MAX);
  c_fp_irq: cover property (fp_irq && irq_any);

endmodule : cmd_decoder

// file: dv/cmd_slave_model.sv
// slave-side model: ram, flash and peripheral bridge answering the decoder
`timescale 1ns/1ns
module cmd_slave_model (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // decoder side
  input  wire logic         hreadyout,
  input  wire logic [1:0]   htrans,
  input  wire logic         flash_sel,
  input  wire logic [7:0]   flash_page,
  input  wire logic         periph_sel,
  input  wire logic [5:0]   periph_id,
  // answers
  output logic      [287:0] ram_rdata,
  output logic      [31:0]  flash_rdata,
  output logic      [31:0]  periph_rdata,
  output logic              periph_hreadyout,
  output logic              periph_hresp
);
  logic [7:0] page_q;
  logic [5:0] id_q;
  logic       busy_q;
  logic       tgl_q;

  // each ram slave answers with its own index so a wrong select shows
  for (genvar n = 0; n < 9; n++) begin : g_ram
    assign ram_rdata[32*n+:32] = 32'h5a5a_0000 + n;
  end

  // page and id are latched at accept, so late address changes cannot leak
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= 8'h00;
      id_q   <= 6'h00;
      busy_q <= 1'b0;
      tgl_q  <= 1'b0;
    end else begin
      tgl_q  <= ~tgl_q;
      busy_q <= periph_sel && htrans[1] && hreadyout;
      if (flash_sel && htrans[1] && hreadyout) page_q <= flash_page;
      if (periph_sel && htrans[1] && hreadyout) id_q <= periph_id;
    end
  end

  assign flash_rdata      = {24'hf1a500, page_q};
  // the bridge is slow by one cycle; data toggles while busy so stale values never match
  assign periph_hreadyout = !busy_q;
  assign periph_hresp     = 1'b0;
  assign periph_rdata     = busy_q ? {tgl_q ? 26'h3ffffff : 26'h0, ~id_q} : {26'h2f80000, id_q};
endmodule : cmd_slave_model

// file: dv/testbench.sv
// self-checking bench for the core memory address decoder
`timescale 1ns/1ns
module testbench;
  logic core_clk, rst_n, hwrite, hmaster_dma, icache_en, icache_hit, sys_off, core_running, debug_mode, tick_clear;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [21:0] ram_pwr_on, ram_ret_off;
  logic [5:0]  fp_exc_flags;
  logic [47:0] periph_irq;
  logic [143:0] irq_prio;
  logic [23:0] tick_reload;
  logic hreadyout, hresp, flash_sel, periph_sel, fp_irq, irq_any, tick_wrap, periph_hreadyout, periph_hresp;
  logic [31:0] hrdata, flash_rdata, periph_rdata, s_rd;
  logic [287:0] ram_rdata;
  logic [8:0] ram_sel, s_rs;
  logic [2:0] ram_sect, s_sc;
  logic [7:0] flash_page, s_pg;
  logic [5:0] periph_id, irq_top, s_id;
  logic [1:0] gpio_port_sel, s_gp;
  logic [21:0] ram_sect_pwr;
  logic [47:0] irq_pend;
  logic [23:0] tick_value;
  logic s_fs, s_ps;
  int fails, n_compared, cyc;

  cmd_decoder u_dut (.core_clk(core_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hprot(4'h3), .hmaster_dma(hmaster_dma), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ram_sel(ram_sel), .ram_sect(ram_sect), .ram_rdata(ram_rdata), .flash_sel(flash_sel),
    .flash_page(flash_page), .flash_rdata(flash_rdata), .icache_en(icache_en), .icache_hit(icache_hit),
    .periph_sel(periph_sel), .periph_id(periph_id), .gpio_port_sel(gpio_port_sel),
    .periph_rdata(periph_rdata), .periph_hreadyout(periph_hreadyout), .periph_hresp(periph_hresp),
    .sys_off(sys_off), .ram_pwr_on(ram_pwr_on), .ram_ret_off(ram_ret_off), .ram_sect_pwr(ram_sect_pwr),
    .fp_exc_flags(fp_exc_flags), .periph_irq(periph_irq), .irq_prio(irq_prio), .fp_irq(fp_irq),
    .irq_pend(irq_pend), .irq_any(irq_any), .irq_top(irq_top), .core_running(core_running),
    .debug_mode(debug_mode), .tick_reload(tick_reload), .tick_clear(tick_clear),
    .tick_value(tick_value), .tick_wrap(tick_wrap));
  cmd_slave_model u_slv (.core_clk(core_clk), .rst_n(rst_n), .hreadyout(hreadyout), .htrans(htrans),
    .flash_sel(flash_sel), .flash_page(flash_page), .periph_sel(periph_sel), .periph_id(periph_id),
    .ram_rdata(ram_rdata), .flash_rdata(flash_rdata), .periph_rdata(periph_rdata),
    .periph_hreadyout(periph_hreadyout), .periph_hresp(periph_hresp));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk

  // one transfer; address-phase selects are snapshot once settled
  task automatic acc(input logic [31:0] a, input logic w, input logic d, input int ews, input logic eer);
    int ws;
    @(posedge core_clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hmaster_dma <= d;
    #1;
    {s_rs, s_sc, s_fs, s_pg, s_ps, s_id, s_gp} = {ram_sel, ram_sect, flash_sel, flash_page,
                                                  periph_sel, periph_id, gpio_port_sel};
    @(posedge core_clk);
    htrans <= 2'h0;
    ws = 0;
    #1;
    while (hreadyout !== 1'b1 && ws < 20) begin
      chk("hresp_first", eer, hresp);
      @(posedge core_clk);
      #1;
      ws++;
    end
    s_rd = hrdata;
    chk("wait_states", ews, ws);
    chk("hresp", eer, hresp);
  endtask : acc

  task automatic t_ram;
    acc(32'h2000_2000, 1'b0, 1'b0, 0, 1'b0);
    chk("ram_sel", 9'h002, s_rs);
    chk("ram_sect", 3'h0, s_sc);
    chk("hrdata", 32'h5a5a_0001, s_rd);
    acc(32'h0080_3000, 1'b1, 1'b1, 0, 1'b0);
    chk("alias_sel", 9'h002, s_rs);
    chk("alias_sect", 3'h1, s_sc);
    acc(32'h2000_f000, 1'b0, 1'b0, 0, 1'b0);
    chk("top_small", {9'h080, 3'h1}, {s_rs, s_sc});
    acc(32'h2001_0000, 1'b0, 1'b0, 0, 1'b0);
    chk("big_first", {9'h100, 3'h0}, {s_rs, s_sc});
    acc(32'h0083_f000, 1'b0, 1'b0, 0, 1'b0);
    chk("big_last", {9'h100, 3'h5, 1'b1}, {s_rs, s_sc, 32'h5a5a_0008 == s_rd});
    acc(32'h2004_0000, 1'b0, 1'b0, 1, 1'b1);
    $display("test ram done");
  endtask : t_ram

  task automatic t_flash;
    acc(32'h000f_f000, 1'b0, 1'b0, 2, 1'b0);
    chk("flash_page", {1'b1, 8'hff}, {s_fs, s_pg});
    chk("flash_data", 32'hf1a5_00ff, s_rd);
    icache_en <= 1'b1;
    icache_hit <= 1'b1;
    acc(32'h0000_0100, 1'b0, 1'b0, 0, 1'b0);
    icache_hit <= 1'b0;
    acc(32'h0000_1100, 1'b0, 1'b1, 3, 1'b0);
    icache_en <= 1'b0;
    acc(32'h0000_0100, 1'b1, 1'b0, 1, 1'b1);
    $display("test flash done");
  endtask : t_flash

  task automatic t_periph;
    acc(32'h4000_f000, 1'b0, 1'b0, 1, 1'b0);
    chk("cipher_id", {1'b1, 6'h0f, 32'hbe00_000f}, {s_ps, s_id, s_rd});
    acc(32'h4000_2000, 1'b1, 1'b0, 1, 1'b0);
    chk("serial_id", {1'b1, 6'h02}, {s_ps, s_id});
    acc(32'h5000_0000, 1'b0, 1'b0, 1, 1'b0);
    chk("port_zero", 2'b01, s_gp);
    acc(32'h5000_0300, 1'b0, 1'b0, 1, 1'b0);
    chk("port_one", 2'b10, s_gp);
    acc(32'h4000_2000, 1'b0, 1'b1, 0, 1'b0);
    chk("dma_periph", 1'b0, s_ps);
    acc(32'h3000_0000, 1'b0, 1'b0, 1, 1'b1);
    acc(32'h4002_c000, 1'b0, 1'b0, 1, 1'b1);
    $display("test periph done");
  endtask : t_periph

  task automatic t_tick;
    @(posedge core_clk) tick_clear <= 1'b1;
    @(posedge core_clk) tick_clear <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 chk("tick_hold", 24'h5, tick_value);
    @(posedge core_clk) core_running <= 1'b1;
    repeat (3) @(posedge core_clk);
    core_running <= 1'b0;
    #1 chk("tick_run", 24'h2, tick_value);
    @(posedge core_clk) debug_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    debug_mode <= 1'b0;
    #1 chk("tick_debug", 24'h0, tick_value);
    @(posedge core_clk) core_running <= 1'b1;
    @(posedge core_clk) core_running <= 1'b0;
    #1 chk("tick_wrap", {1'b1, 24'h5}, {tick_wrap, tick_value});
    $display("test tick done");
  endtask : t_tick

  task automatic t_irq_pwr;
    @(posedge core_clk) fp_exc_flags <= 6'h04;
    @(posedge core_clk) #1 chk("fp_irq_set", 1'b1, fp_irq);
    repeat (5) @(posedge core_clk);
    #1 chk("fp_irq_hold", {1'b1, 1'b1}, {fp_irq, irq_pend[38]});
    @(posedge core_clk) fp_exc_flags <= 6'h00;
    @(posedge core_clk) #1 chk("fp_irq_clr", 1'b0, fp_irq);
    irq_prio[15+:3] <= 3'h5;
    irq_prio[120+:3] <= 3'h2;
    @(posedge core_clk) periph_irq <= 48'h0100_0000_0020;
    repeat (3) @(posedge core_clk);
    #1 chk("irq_top", {1'b1, 6'd40}, {irq_any, irq_top});
    chk("ram_pwr_on", 22'h2aaaaa, ram_sect_pwr);
    @(posedge core_clk) sys_off <= 1'b1;
    @(posedge core_clk) #1 chk("ram_pwr_off", 22'h155555, ram_sect_pwr);
    $display("test irq and power done");
  endtask : t_irq_pwr

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    {fails, n_compared, cyc} = '0;
    {rst_n, hwrite, hmaster_dma, icache_en, icache_hit, sys_off, core_running, debug_mode, tick_clear} = '0;
    {haddr, htrans, fp_exc_flags, periph_irq} = '0;
    ram_pwr_on = 22'h2aaaaa;
    ram_ret_off = 22'h155555;
    irq_prio = {48{3'h7}};
    tick_reload = 24'h000005;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_ram();
    t_flash();
    t_periph();
    t_tick();
    t_irq_pwr();
    stop_test();
  end
endmodule : testbench
